/* File: pls_pkg.sv */
// Shared constants of the link status register bank
package pls_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FLD = 6'h0f;  // Fast-link-drop cause
   localparam logic [5:0] IDX_STS = 6'h10;  // Summary status word
   localparam logic [5:0] IDX_CTRL = 6'h1f; // Capture control
   localparam int ADDR_LSB = 2;             // Word aligned decode
   localparam int ADDR_MSB = 7;             // Highest decoded bit

   ////////////////////////////////////////////////////////////////////////////
   // Summary status bit positions
   localparam int B_MDIX = 14;
   localparam int B_RXERR = 13;
   localparam int B_POL = 12;
   localparam int B_FC = 11;
   localparam int B_SD = 10;
   localparam int B_DL = 9;
   localparam int B_PAGE = 8;
   localparam int B_INTR = 7;
   localparam int B_RF = 6;
   localparam int B_JAB = 5;
   localparam int B_AN = 4;
   localparam int B_LB = 3;
   localparam int B_DUP = 2;
   localparam int B_SPD = 1;
   localparam int B_LINK = 0;
   localparam logic [15:0] STS_RESET = 16'h0002; // Only 10 Mbps speed set

   ////////////////////////////////////////////////////////////////////////////
   // Fast-link-drop cause field
   localparam int FLD_LSB = 4;  // Field starts at bit 4
   localparam int FLD_W = 5;    // Five causes

   ////////////////////////////////////////////////////////////////////////////
   // Sticky latch slots
   localparam int L_RXERR = 5;
   localparam int L_FC = 6;
   localparam int L_RF = 7;
   localparam int N_LATCH = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   localparam int CTRL_CAP = 0;                   // Cause capture enable
   localparam logic [15:0] CTRL_RESET = 16'h0001;
   localparam logic [15:0] CTRL_MASK = 16'h0001;  // Writable bits

endpackage

/* File: pls_sticky.sv */
// Bank of sticky flags where a set beats a simultaneous clear
module pls_sticky
   import pls_pkg::*;
#(
   parameter int WIDTH = N_LATCH // Number of flags
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] set_evt,
   input wire logic [WIDTH-1:0] clr_req,
   output logic [WIDTH-1:0] flag
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check
   if (WIDTH < 1) begin : g_bad_width
      $error("pls_sticky needs at least one flag");
   end

   // Whole state of the bank
   typedef struct packed {
      logic [WIDTH-1:0] flag; // Latched flags
   } pls_stk_t;

   pls_stk_t st_r;  // Registered state
   pls_stk_t st_nxt; // Next state
   logic [WIDTH-1:0] bit_nxt; // Per-bit next value

   ////////////////////////////////////////////////////////////////////////////
   // One equation per flag; set has priority so no event is lost
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign bit_nxt[i] = set_evt[i] | (st_r.flag[i] & ~clr_req[i]);
   end

   // Next-state copy
   always_comb begin
      st_nxt = st_r;
      st_nxt.flag = bit_nxt;
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_set_beats_clr: assert property (@(posedge ref_clk) disable iff (rst)
      (set_evt[0] && clr_req[0]) |=> flag[0])
      else $error("Flag lost on set during clear");

endmodule // pls_sticky

/* File: pls_status_regs.sv */
// Operation
// - Cause bit latches on fired drop, read clears
// - Cause bits: energy, SNR, MLT3, RX error, descrambler
// - Bit 14 shows crossover swapped pairs
// - Bit 13 latches receive error, counter read clears
// - Bit 12 mirrors polarity, own read keeps
// - Bit 11 latches false carrier, counter read clears
// - Bit 10 shows signal detect
// - Bit 9 shows descrambler lock
// - Bit 8 mirrors page received flag
// - Bit 7 shows pending internal interrupt
// - Bit 6 latches remote fault, status read clears
// - Bit 5 mirrors jabber, own read keeps
// - Bit 4 shows auto-negotiation complete
// - Bit 3 shows MII loopback enabled
// - Summary at index 10h, resets to 0002h
// - Bit 2 shows full duplex
// - Bit 1 shows 10 Mbps speed
// - Bit 0 mirrors link status
module pls_status_regs
   import pls_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Core events and levels
   input wire logic [FLD_W-1:0] fld_drop_evt,
   input wire logic mdix_swapped,
   input wire logic rx_err_evt,
   input wire logic rx_err_cnt_rd,
   input wire logic pol_inverted,
   input wire logic false_carrier_evt,
   input wire logic fc_cnt_rd,
   input wire logic signal_detect,
   input wire logic descr_lock,
   input wire logic page_received,
   input wire logic intr_pending,
   input wire logic remote_fault_evt,
   input wire logic basic_status_rd,
   input wire logic jabber_det,
   input wire logic an_complete,
   input wire logic mii_loopback,
   input wire logic full_duplex,
   input wire logic speed_10,
   input wire logic link_up
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [31:0] rdata;   // Read data for the data phase
      logic ready;          // Ready toward the master
      logic resp;           // Always OKAY
      logic wr_pend;        // Write data phase follows
      logic [5:0] wr_idx;   // Index of pending write
      logic [15:0] ctrl;    // Control register
      logic [15:0] mir;     // Registered mirror bits
   } pls_state_t;

   pls_state_t st_r;   // Registered state
   pls_state_t st_nxt; // Next state

   logic [N_LATCH-1:0] lat_set; // Latch set events
   logic [N_LATCH-1:0] lat_clr; // Latch clear requests
   logic [N_LATCH-1:0] lat;     // Latched flags
   logic [5:0] a_idx;           // Address phase index
   logic a_valid;               // Address phase taken
   logic rd_fld;                // Read of cause register
   logic rd_sts;                // Read of summary register
   logic [15:0] sts_word;       // Summary as software sees it
   logic [15:0] fld_word;       // Cause register view
   logic [15:0] rd_mux;         // Selected read value

   ////////////////////////////////////////////////////////////////////////////
   // Address phase decode
   assign a_idx = haddr[ADDR_MSB:ADDR_LSB];
   assign a_valid = hsel & htrans[1] & hready;
   assign rd_fld = a_valid & ~hwrite & (a_idx == IDX_FLD);
   assign rd_sts = a_valid & ~hwrite & (a_idx == IDX_STS);

   ////////////////////////////////////////////////////////////////////////////
   // Sticky latches
   // Cause capture can be paused by software, for example during
   // link bring-up, without losing the other latches
   always_comb begin
      lat_set = '0;
      lat_clr = '0;
      // Cause bits set only when capture is enabled
      if (st_r.ctrl[CTRL_CAP]) begin
         lat_set[FLD_W-1:0] = fld_drop_evt;
      end
      lat_set[L_RXERR] = rx_err_evt;
      lat_set[L_FC] = false_carrier_evt;
      lat_set[L_RF] = remote_fault_evt;
      // Clear sources; the summary read itself clears nothing
      lat_clr[FLD_W-1:0] = {FLD_W{rd_fld}};
      lat_clr[L_RXERR] = rx_err_cnt_rd;
      lat_clr[L_FC] = fc_cnt_rd;
      lat_clr[L_RF] = basic_status_rd;
   end

   pls_sticky #(
      .WIDTH(N_LATCH)
   ) u_latch (
      .ref_clk(ref_clk),
      .rst(rst),
      .set_evt(lat_set),
      .clr_req(lat_clr),
      .flag(lat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register views
   // Cause bits in order energy, SNR, MLT3, RX error, sync loss
   always_comb begin
      fld_word = '0;
      fld_word[FLD_LSB +: FLD_W] = lat[FLD_W-1:0];
   end

   // Summary: mirrors plus latched bits; reserved bit 15 stays zero
   always_comb begin
      sts_word = st_r.mir;
      sts_word[B_RXERR] = lat[L_RXERR];
      sts_word[B_FC] = lat[L_FC];
      sts_word[B_RF] = lat[L_RF];
   end

   // Read multiplexer; unmapped indices read zero
   always_comb begin
      unique case (a_idx)
         IDX_FLD: rd_mux = fld_word;
         IDX_STS: rd_mux = sts_word;
         IDX_CTRL: rd_mux = st_r.ctrl;
         default: rd_mux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b1; // Zero wait states
      st_nxt.resp = 1'b0;  // Always OKAY
      // Mirrors are sampled each cycle; one cycle of latency
      st_nxt.mir = '0;
      st_nxt.mir[B_MDIX] = mdix_swapped;
      st_nxt.mir[B_POL] = pol_inverted;
      st_nxt.mir[B_SD] = signal_detect;
      st_nxt.mir[B_DL] = descr_lock;
      st_nxt.mir[B_PAGE] = page_received;
      st_nxt.mir[B_INTR] = intr_pending;
      st_nxt.mir[B_JAB] = jabber_det;
      st_nxt.mir[B_AN] = an_complete;
      st_nxt.mir[B_LB] = mii_loopback;
      st_nxt.mir[B_DUP] = full_duplex;
      st_nxt.mir[B_SPD] = speed_10;
      st_nxt.mir[B_LINK] = link_up;
      // Data phase of a write: only the control bits take it
      if (st_r.wr_pend && (st_r.wr_idx == IDX_CTRL)) begin
         st_nxt.ctrl = hwdata[15:0] & CTRL_MASK;
      end
      // Address phase
      st_nxt.wr_pend = a_valid & hwrite;
      st_nxt.wr_idx = a_idx;
      if (a_valid && !hwrite) begin
         // Read data is captured now so hrdata comes from a flop
         st_nxt.rdata = {16'h0000, rd_mux};
      end else begin
         st_nxt.rdata = '0;
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r.rdata <= '0;
         st_r.ready <= 1'b1;
         st_r.resp <= 1'b0;
         st_r.wr_pend <= 1'b0;
         st_r.wr_idx <= '0;
         st_r.ctrl <= CTRL_RESET;
         st_r.mir <= STS_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign hrdata = st_r.rdata;
   assign hreadyout = st_r.ready;
   assign hresp = st_r.resp;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_fld_latch: assert property (
      (fld_drop_evt[0] && st_r.ctrl[CTRL_CAP]) |=> lat[0] ##1 (lat[0] || $past(rd_fld)))
      else $error("Cause bit did not latch");

   a_fld_read_clear: assert property (
      (rd_fld && fld_drop_evt == '0) |=> (lat[FLD_W-1:0] == '0))
      else $error("Cause read did not clear");

   a_fld_read_map: assert property (
      rd_fld |=> (hrdata[FLD_LSB +: FLD_W] == $past(lat[FLD_W-1:0])))
      else $error("Cause field misplaced");

   a_fld_gated: assert property (
      (!st_r.ctrl[CTRL_CAP] && !lat[1] && !fld_drop_evt[1]) |=> !lat[1])
      else $error("Cause set while capture off");

   a_mirror_follow: assert property (
      ##1 (st_r.mir[B_MDIX] == $past(mdix_swapped) && st_r.mir[B_LINK] == $past(link_up)))
      else $error("Mirror bits lag");

   a_rxerr_hold: assert property (
      (rx_err_evt ##1 !rx_err_cnt_rd [*3]) |-> lat[L_RXERR])
      else $error("Receive error latch lost");

   a_fc_clear: assert property (
      (fc_cnt_rd && !false_carrier_evt) |=> !lat[L_FC])
      else $error("False carrier latch not cleared");

   a_rf_set_wins: assert property (
      (remote_fault_evt && basic_status_rd) |=> lat[L_RF])
      else $error("Remote fault lost on clear");

   a_sts_read_map: assert property (
      rd_sts |=> (hrdata[15:0] == $past(sts_word)))
      else $error("Summary read mismatch");

   a_sts_no_clear: assert property (
      (rd_sts && lat[L_RXERR] && !rx_err_cnt_rd) |=> lat[L_RXERR])
      else $error("Summary read cleared a latch");

   a_reserved_zero: assert property (
      (hrdata[31:16] == 16'h0000) && (st_r.ctrl & ~CTRL_MASK) == 16'h0000)
      else $error("Reserved bits not zero");

   a_bus_okay: assert property (
      hreadyout && !hresp)
      else $error("Bus answer not ready or not OKAY");

   // Mirrors, seen end to end: input two edges back shows on the read data
   a_pol_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_POL] == $past(pol_inverted, 2)))
      else $error("Polarity bit wrong on read");

   a_sd_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_SD] == $past(signal_detect, 2)))
      else $error("Signal detect bit wrong on read");

   a_lock_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_DL] == $past(descr_lock, 2)))
      else $error("Descrambler lock bit wrong on read");

   a_page_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_PAGE] == $past(page_received, 2)))
      else $error("Page received bit wrong on read");

   a_intr_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_INTR] == $past(intr_pending, 2)))
      else $error("Interrupt pending bit wrong on read");

   a_jabber_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_JAB] == $past(jabber_det, 2)))
      else $error("Jabber bit wrong on read");

   a_an_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_AN] == $past(an_complete, 2)))
      else $error("Negotiation done bit wrong on read");

   a_loop_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_LB] == $past(mii_loopback, 2)))
      else $error("Loopback bit wrong on read");

   a_duplex_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_DUP] == $past(full_duplex, 2)))
      else $error("Duplex bit wrong on read");

   a_speed_mirror: assert property (
      (rd_sts && !$past(rst)) |=> (hrdata[B_SPD] == $past(speed_10, 2)))
      else $error("Speed bit wrong on read");

   // Latched bits: an event one edge back is visible to the next read
   a_rxerr_seen: assert property (
      (rd_sts && $past(rx_err_evt) && !$past(rst)) |=> hrdata[B_RXERR])
      else $error("Receive error bit missing on read");

   a_rxerr_clear: assert property (
      (rx_err_cnt_rd && !rx_err_evt) |=> !lat[L_RXERR])
      else $error("Receive error latch not cleared");

   a_fc_seen: assert property (
      (rd_sts && $past(false_carrier_evt) && !$past(rst)) |=> hrdata[B_FC])
      else $error("False carrier bit missing on read");

   a_rf_seen: assert property (
      (rd_sts && $past(remote_fault_evt) && !$past(rst)) |=> hrdata[B_RF])
      else $error("Remote fault bit missing on read");

   a_rf_clear: assert property (
      (basic_status_rd && !remote_fault_evt) |=> !lat[L_RF])
      else $error("Remote fault latch not cleared");

   a_fld_hold: assert property (
      (lat[0] && !rd_fld) |=> lat[0])
      else $error("Cause bit dropped without a read");

   // Cause order: lowest cause in the field's low bit, sync loss on top
   a_fld_order_lo: assert property (
      (rd_fld && $past(fld_drop_evt[0]) && $past(st_r.ctrl[CTRL_CAP]) && !$past(rst))
      |=> hrdata[FLD_LSB])
      else $error("Energy loss cause not in low bit");

   a_fld_order_hi: assert property (
      (rd_fld && $past(fld_drop_evt[FLD_W-1]) && $past(st_r.ctrl[CTRL_CAP]) && !$past(rst))
      |=> hrdata[FLD_LSB+FLD_W-1])
      else $error("Sync loss cause not in top bit");

   a_fld_reserved: assert property (
      rd_fld |=> ((hrdata >> (FLD_LSB + FLD_W)) == '0 && hrdata[FLD_LSB-1:0] == '0))
      else $error("Cause register reserved bits set");

   a_sts_top_zero: assert property (
      rd_sts |=> !hrdata[B_MDIX+1])
      else $error("Summary reserved bit set");

   // Right after release the summary holds its reset word, no latch set
   a_reset_value: assert property (
      $fell(rst) |-> (st_r.mir == STS_RESET && lat == '0))
      else $error("Summary not at reset value");

   c_fld_read_set: cover property (rd_fld && lat[0]);
   c_sts_read: cover property (rd_sts ##1 hready);
   c_ctrl_write: cover property (st_r.wr_pend && st_r.wr_idx == IDX_CTRL);
   c_rf_collide: cover property (remote_fault_evt && basic_status_rd);
   c_fld_collide: cover property (rd_fld && fld_drop_evt[0] && st_r.ctrl[CTRL_CAP]);

endmodule // pls_status_regs

/* File: pls_core_model.sv */
// Stand-in for the transceiver core and the link partner behind it
module pls_core_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic active,
   output logic [10:0] evt = 11'h000,
   output logic [11:0] lvl = 12'h002
);
   timeunit 1ns;
   timeprecision 1ps;

   /////////////////////////////////////////////////////////////
   // Pulses fire about one cycle in four, levels flip about one in eight.
   // Dense enough that set and clear often collide in one cycle.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         evt <= 11'h000;
         lvl <= 12'h002; // Speed shows 10 Mbps after reset
      end else if (active) begin
         evt <= 11'($urandom) & 11'($urandom);
         lvl <= lvl ^ (12'($urandom) & 12'($urandom) & 12'($urandom));
      end else begin
         evt <= 11'h000; // Quiet: no pulses, levels hold
      end
   end
endmodule // pls_core_model

/* File: tb_phy_link_status_registers.sv */
// Self-checking bench for the link status register bank
module tb_phy_link_status_registers
   import pls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   /////////////////////////////////////////////////////////////
   // Bus, core and bookkeeping signals
   logic ref_clk = 1'b0;
   logic rst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic act = 1'b0; // Core stand-in running
   logic [10:0] evt; // Event and clearing pulses
   logic [11:0] lvl; // Mirrored levels
   logic [31:0] tab [4] = '{32'h3c, 32'h40, 32'h7c, 32'h40}; // Mapped places
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;

   pls_core_model pls_core_model_i (.ref_clk(ref_clk), .rst(rst), .active(act), .evt(evt), .lvl(lvl));

   // Single slave, so its ready is the bus ready
   pls_status_regs pls_status_regs_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fld_drop_evt(evt[4:0]),
      .mdix_swapped(lvl[11]), .rx_err_evt(evt[5]), .rx_err_cnt_rd(evt[6]), .pol_inverted(lvl[10]),
      .false_carrier_evt(evt[7]), .fc_cnt_rd(evt[8]), .signal_detect(lvl[9]), .descr_lock(lvl[8]),
      .page_received(lvl[7]), .intr_pending(lvl[6]), .remote_fault_evt(evt[9]),
      .basic_status_rd(evt[10]), .jabber_det(lvl[5]), .an_complete(lvl[4]), .mii_loopback(lvl[3]),
      .full_duplex(lvl[2]), .speed_10(lvl[1]), .link_up(lvl[0]));

   /////////////////////////////////////////////////////////////
   // Reference model; snapshots read data at the address edge
   logic [15:0] m_lv; // Levels, one cycle behind
   logic [2:0] m_lat; // Receive error, false carrier, remote fault
   logic [4:0] m_fld; // Cause latches
   logic m_cap; // Cause capture enable
   logic m_wp; // Write data phase pending
   logic [5:0] m_wi; // Index of that write
   logic [31:0] m_rd; // Expected read data
   wire rd_ph = hsel & htrans[1] & ~hwrite & hreadyout;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         m_lv = STS_RESET;
         m_lat = 3'h0;
         m_fld = 5'h0;
         m_cap = 1'b1;
         m_wp = 1'b0;
      end else begin
         if (rd_ph) begin
            m_rd = 32'h0; // Reserved and unmapped read zero
            if (haddr[7:2] == IDX_FLD) m_rd[8:4] = m_fld;
            if (haddr[7:2] == IDX_STS) m_rd[15:0] = m_lv | {2'b0, m_lat[0], 1'b0, m_lat[1], 4'h0, m_lat[2], 6'h0};
            if (haddr[7:2] == IDX_CTRL) m_rd[0] = m_cap;
         end
         // Clear first, then set, so a colliding event survives
         m_fld = (rd_ph && haddr[7:2] == IDX_FLD ? 5'h0 : m_fld) | (evt[4:0] & {5{m_cap}});
         m_lat[0] = (m_lat[0] & ~evt[6]) | evt[5];
         m_lat[1] = (m_lat[1] & ~evt[8]) | evt[7];
         m_lat[2] = (m_lat[2] & ~evt[10]) | evt[9];
         m_lv = {1'b0, lvl[11], 1'b0, lvl[10], 1'b0, lvl[9:6], 1'b0, lvl[5:0]};
         if (m_wp && m_wi == IDX_CTRL) m_cap = hwdata[0];
         m_wp = hsel & htrans[1] & hwrite & hreadyout;
         m_wi = haddr[7:2];
      end
   end

   /////////////////////////////////////////////////////////////
   // One single transfer; entered just after a rising edge
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single exit point of the run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   /////////////////////////////////////////////////////////////
   // Clock and hang guard; whole run needs well under 2000 cycles
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         finish_test();
      end
   end

   /////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic [31:0] a;
      logic w;
      void'($urandom(37611));
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, read-only and unmapped places
      xfer(32'h40, 1'b0, 32'h0, rd);
      check(rd, 32'h0000_0002);
      xfer(32'h40, 1'b1, 32'hffff_ffff, rd);
      xfer(32'h40, 1'b0, 32'h0, rd);
      check(rd, 32'h0000_0002);
      xfer(32'h3c, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      xfer(32'h44, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      xfer(32'h7c, 1'b0, 32'h0, rd);
      check(rd, 32'h0000_0001);
      xfer(32'h7c, 1'b1, 32'hffff_fffe, rd);
      xfer(32'h7c, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      xfer(32'h7c, 1'b1, 32'h0000_0001, rd);
      $display("Reset test done");
      // Random core activity under mixed bus traffic
      act <= 1'b1;
      repeat (600) begin
         a = {24'h0, 6'($urandom), 2'b00};
         if ($urandom % 4 != 0) a = tab[$urandom % 4];
         w = ($urandom % 4) == 0;
         xfer(a, w, $urandom, rd);
         check({31'h0, hresp}, 32'h0);
         if (!w) check(rd, m_rd);
      end
      $display("Random traffic test done");
      // Reset in mid-run drops every latch
      act <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      xfer(32'h40, 1'b0, 32'h0, rd);
      check(rd, 32'h0000_0002);
      xfer(32'h3c, 1'b0, 32'h0, rd);
      check(rd, 32'h0);
      xfer(32'h7c, 1'b0, 32'h0, rd);
      check(rd, 32'h0000_0001);
      $display("Second reset test done");
      finish_test();
   end
endmodule // tb_phy_link_status_registers
